/* hdl/irq_pin_driver.sv */
// one interrupt pad: polarity and push-pull or open-drain drive
module irq_pin_driver
    import sensor_ctrl_pkg::*;
(
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    // combined request and pad setup
    input  wire logic assert_i,
    input  wire logic polarity_i,
    input  wire logic drive_type_i,
    // pad
    output logic      pin_o,
    output logic      pin_oe_o
);

    // ------------------------------------------------------------------
    // pad logic
    // ------------------------------------------------------------------
    // open drain drives only the asserted level, push-pull drives both
    wire level_d = assert_i ? polarity_i : ~polarity_i;
    wire oe_d    = drive_type_i ? assert_i : 1'b1;

    // registered so the pad never sees decode glitches
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            pin_o    <= 1'b1;  // idle level of active-low push-pull
            pin_oe_o <= 1'b1;
        end else begin
            pin_o    <= drive_type_i ? polarity_i : level_d;
            pin_oe_o <= oe_d;
        end
    end

endmodule : irq_pin_driver

/* hdl/sensor_acq_irq_control_regs.sv */
// acquisition interval, alarm target and interrupt pin control bank
module sensor_acq_irq_control_regs
    import sensor_ctrl_pkg::*;
#(
    parameter int unsigned CYCLES_PER_UNIT_P = CYCLES_PER_UNIT
) (
    // clock and reset
    input  wire logic                 clk_i,
    input  wire logic                 rst_n_i,
    // register port
    input  wire logic                 reg_wr_i,
    input  wire logic                 reg_rd_i,
    input  wire logic [7:0]           reg_addr_i,
    input  wire logic [7:0]           reg_wdata_i,
    output logic      [7:0]           reg_rdata_o,
    // mode and routing from the rest of the device
    input  wire logic                 active_run_select_i,
    input  wire logic [7:0]           irq_pin_routing_i,
    // measurement results and programmed targets
    input  wire logic                 result_valid_i,
    input  wire logic [PRESS_W-1:0]   pressure_result_i,
    input  wire logic [TEMP_W-1:0]    temp_result_i,
    input  wire logic [15:0]          pressure_target_i,
    input  wire logic [7:0]           temperature_target_i,
    // functional block event flags, bit order as the enable register
    input  wire logic [7:0]           src_flags_i,
    // alarm comparison targets
    output logic [PRESS_W-1:0]        alarm_press_target_o,
    output logic [TEMP_W-1:0]         alarm_temp_target_o,
    output logic                      target_captured_o,
    // acquisition pacing
    output logic                      acq_start_o,
    // interrupt pads
    output logic                      irq_pin_a_o,
    output logic                      irq_pin_a_oe_o,
    output logic                      irq_pin_b_o,
    output logic                      irq_pin_b_oe_o
);

    // ------------------------------------------------------------------
    // functions
    // ------------------------------------------------------------------
    // keeps reserved bits of a register at zero on every write
    function automatic logic [7:0] masked_write(input logic [7:0] data,
                                                input logic [7:0] mask);
        masked_write = data & mask;
    endfunction : masked_write

    // ------------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------------
    logic [7:0] acq_alarm_control_q;
    logic [7:0] irq_pin_config_q;
    logic [7:0] irq_source_enable_q;

    wire wr_acq = reg_wr_i && (reg_addr_i == ADDR_ACQ_ALARM_CTRL);
    wire wr_cfg = reg_wr_i && (reg_addr_i == ADDR_IRQ_PIN_CFG);
    wire wr_en  = reg_wr_i && (reg_addr_i == ADDR_IRQ_SRC_EN);

    // write path, reserved positions are dropped by the mask
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            acq_alarm_control_q <= RST_ACQ_ALARM_CTRL;
            irq_pin_config_q    <= RST_IRQ_PIN_CFG;
            irq_source_enable_q <= RST_IRQ_SRC_EN;
        end else begin
            if (wr_acq)
                acq_alarm_control_q <= masked_write(reg_wdata_i,
                                           MASK_ACQ_ALARM_CTRL);
            if (wr_cfg)
                irq_pin_config_q <= masked_write(reg_wdata_i,
                                        MASK_IRQ_PIN_CFG);
            if (wr_en)
                irq_source_enable_q <= masked_write(reg_wdata_i,
                                           MASK_IRQ_SRC_EN);
        end
    end

    // ------------------------------------------------------------------
    // field decode
    // ------------------------------------------------------------------
    wire       capture_bit      = acq_alarm_control_q[CAPTURE_TARGET_BIT];
    wire       target_sel       = acq_alarm_control_q[TARGET_SEL_BIT];
    wire [3:0] acq_interval_exp =
        acq_alarm_control_q[ACQ_EXP_MSB:ACQ_EXP_LSB];
    wire       irq_a_polarity   = irq_pin_config_q[IRQ_A_POL_BIT];
    wire       irq_a_drive_type = irq_pin_config_q[IRQ_A_DRIVE_BIT];
    wire       irq_b_polarity   = irq_pin_config_q[IRQ_B_POL_BIT];
    wire       irq_b_drive_type = irq_pin_config_q[IRQ_B_DRIVE_BIT];

    // ------------------------------------------------------------------
    // read path
    // ------------------------------------------------------------------
    // unmapped offsets read zero; reserved bits are never stored
    logic [7:0] rdata_d;
    assign rdata_d =
        (reg_addr_i == ADDR_ACQ_ALARM_CTRL) ? acq_alarm_control_q :
        (reg_addr_i == ADDR_IRQ_PIN_CFG)    ? irq_pin_config_q    :
        (reg_addr_i == ADDR_IRQ_SRC_EN)     ? irq_source_enable_q :
                                              READ_UNMAPPED;

    // read data is held until the next read strobe
    always_ff @(posedge clk_i) begin
        if (!rst_n_i)
            reg_rdata_o <= READ_UNMAPPED;
        else if (reg_rd_i)
            reg_rdata_o <= rdata_d;
    end

    // ------------------------------------------------------------------
    // target capture
    // ------------------------------------------------------------------
    // a 0->1 write of the capture bit arms one capture; holding it set
    // does not rearm, so the host must clear and set again
    logic                capture_arm_q;
    logic                captured_q;
    logic [PRESS_W-1:0]  cap_press_q;
    logic [TEMP_W-1:0]   cap_temp_q;

    wire capture_rise = wr_acq && !capture_bit &&
                        reg_wdata_i[CAPTURE_TARGET_BIT];
    // the stored bit is tested as well, so a clear written just before
    // a result disarms at once instead of one cycle late
    wire capture_now  = capture_arm_q && capture_bit &&
                        result_valid_i;

    // a result in the arming cycle is too early; the next one is taken
    always_ff @(posedge clk_i) begin
        if (!rst_n_i)
            capture_arm_q <= 1'b0;
        else if (capture_rise)
            capture_arm_q <= 1'b1;
        else if (capture_now || !capture_bit)
            capture_arm_q <= 1'b0;
    end

    // captured values; the flag tells the host a valid target exists
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cap_press_q <= '0;
            cap_temp_q  <= '0;
            captured_q  <= 1'b0;
        end else if (capture_now) begin
            cap_press_q <= pressure_result_i;
            cap_temp_q  <= temp_result_i;
            captured_q  <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // alarm target selection
    // ------------------------------------------------------------------
    // programmed targets are aligned to the top of the result word
    wire [PRESS_W-1:0] prog_press = {pressure_target_i, 4'h0};
    wire [TEMP_W-1:0]  prog_temp  = {temperature_target_i, 4'h0};
    wire [PRESS_W-1:0] press_tgt_d = target_sel ? cap_press_q
                                                : prog_press;
    wire [TEMP_W-1:0]  temp_tgt_d  = target_sel ? cap_temp_q
                                                : prog_temp;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            alarm_press_target_o <= '0;
            alarm_temp_target_o  <= '0;
            target_captured_o    <= 1'b0;
        end else begin
            alarm_press_target_o <= press_tgt_d;
            alarm_temp_target_o  <= temp_tgt_d;
            target_captured_o    <= captured_q;
        end
    end

    // ------------------------------------------------------------------
    // acquisition interval timer
    // ------------------------------------------------------------------
    // a prescaler makes one-second ticks, a second counter counts them
    // up to two to the exponent; standby clears both so a new active
    // period always starts from a full interval
    logic [PRESC_W-1:0]   presc_q;
    logic [SEC_CNT_W-1:0] sec_q;

    wire presc_wrap = (presc_q == PRESC_W'(CYCLES_PER_UNIT_P - 1));
    wire [SEC_CNT_W-1:0] sec_last =
        SEC_CNT_W'((32'd1 << acq_interval_exp) - 32'd1);
    wire sec_wrap = presc_wrap && (sec_q >= sec_last);

    always_ff @(posedge clk_i) begin
        if (!rst_n_i || !active_run_select_i) begin
            presc_q <= '0;
            sec_q   <= '0;
        end else begin
            presc_q <= presc_wrap ? '0 : presc_q + 1'b1;
            if (sec_wrap)
                sec_q <= '0;
            else if (presc_wrap)
                sec_q <= sec_q + 1'b1;
        end
    end

    // one-cycle start pulse at the end of each interval
    always_ff @(posedge clk_i) begin
        if (!rst_n_i)
            acq_start_o <= 1'b0;
        else
            acq_start_o <= active_run_select_i && sec_wrap;
    end

    // ------------------------------------------------------------------
    // interrupt gating and routing
    // ------------------------------------------------------------------
    wire [7:0] gated_src = src_flags_i & irq_source_enable_q;
    wire [7:0] to_pin_a  = gated_src & irq_pin_routing_i;
    wire [7:0] to_pin_b  = gated_src & ~irq_pin_routing_i;
    wire       any_a     = |to_pin_a;
    wire       any_b     = |to_pin_b;

    // pad A: polarity and drive from its own config bits
    irq_pin_driver u_pin_a (
        .clk_i        (clk_i),
        .rst_n_i      (rst_n_i),
        .assert_i     (any_a),
        .polarity_i   (irq_a_polarity),
        .drive_type_i (irq_a_drive_type),
        .pin_o        (irq_pin_a_o),
        .pin_oe_o     (irq_pin_a_oe_o)
    );

    // pad B: same structure, second pair of config bits
    irq_pin_driver u_pin_b (
        .clk_i        (clk_i),
        .rst_n_i      (rst_n_i),
        .assert_i     (any_b),
        .polarity_i   (irq_b_polarity),
        .drive_type_i (irq_b_drive_type),
        .pin_o        (irq_pin_b_o),
        .pin_oe_o     (irq_pin_b_oe_o)
    );

endmodule : sensor_acq_irq_control_regs

/* hdl/sensor_ctrl_pkg.sv */
// constants shared by the sensor acquisition and interrupt control bank
package sensor_ctrl_pkg;

    // ------------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_ACQ_ALARM_CTRL = 8'h27;
    localparam logic [7:0] ADDR_IRQ_PIN_CFG    = 8'h28;
    localparam logic [7:0] ADDR_IRQ_SRC_EN     = 8'h29;

    // ------------------------------------------------------------------
    // reset values and writable-bit masks
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_ACQ_ALARM_CTRL  = 8'h00;
    localparam logic [7:0] RST_IRQ_PIN_CFG     = 8'h00;
    localparam logic [7:0] RST_IRQ_SRC_EN      = 8'h00;
    localparam logic [7:0] MASK_ACQ_ALARM_CTRL = 8'h3f;
    localparam logic [7:0] MASK_IRQ_PIN_CFG    = 8'h33;
    localparam logic [7:0] MASK_IRQ_SRC_EN     = 8'hff;
    localparam logic [7:0] READ_UNMAPPED       = 8'h00;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int CAPTURE_TARGET_BIT = 5;
    localparam int TARGET_SEL_BIT     = 4;
    localparam int ACQ_EXP_MSB        = 3;
    localparam int ACQ_EXP_LSB        = 0;
    localparam int IRQ_A_POL_BIT      = 5;
    localparam int IRQ_A_DRIVE_BIT    = 4;
    localparam int IRQ_B_POL_BIT      = 1;
    localparam int IRQ_B_DRIVE_BIT    = 0;

    // ------------------------------------------------------------------
    // widths and timing
    // ------------------------------------------------------------------
    localparam int PRESS_W           = 20;
    localparam int TEMP_W            = 12;
    localparam int SEC_CNT_W         = 15;
    localparam int PRESC_W           = 25;
    localparam int CLK_HZ            = 20_000_000;
    localparam int ACQ_UNIT_S        = 1;
    localparam int CYCLES_PER_UNIT   = CLK_HZ * ACQ_UNIT_S;

endpackage : sensor_ctrl_pkg

/* verification/host_model.sv */
// host side of the register port: one-cycle read and write strobes
module host_model (
    // clock
    input  wire logic       clk_i,
    // register port
    output logic            reg_wr_i,
    output logic            reg_rd_i,
    output logic [7:0]      reg_addr_i,
    output logic [7:0]      reg_wdata_i,
    input  wire logic [7:0] reg_rdata_o
);
    timeunit 1ns;
    timeprecision 1ns;

    // idle bus at time zero
    initial begin
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b0;
        reg_addr_i = 8'h00;
        reg_wdata_i = 8'h00;
    end

    // released lines show the inverse so stale values cannot pass
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(negedge clk_i);
        reg_addr_i = a;
        reg_wdata_i = d;
        reg_wr_i = 1'b1;
        @(negedge clk_i);
        reg_wr_i = 1'b0;
        reg_addr_i = ~a;
        reg_wdata_i = ~d;
    endtask : wr

    // data is taken one edge after the strobe
    task automatic rd(logic [7:0] a, output logic [7:0] d);
        @(negedge clk_i);
        reg_addr_i = a;
        reg_rd_i = 1'b1;
        @(negedge clk_i);
        reg_rd_i = 1'b0;
        reg_addr_i = ~a;
        d = reg_rdata_o;
    endtask : rd
endmodule : host_model

/* verification/sensor_ctrl_checker_assertions.sv */
// port-level assertions for the sensor acquisition and interrupt bank
module sensor_ctrl_checker
    import sensor_ctrl_pkg::*;
#(
    parameter int unsigned CYCLES_PER_UNIT_P = 4
) (
    // clock and reset
    input wire logic               clk_i,
    input wire logic               rst_n_i,
    // register port
    input wire logic               reg_wr_i,
    input wire logic               reg_rd_i,
    input wire logic [7:0]         reg_addr_i,
    input wire logic [7:0]         reg_wdata_i,
    input wire logic [7:0]         reg_rdata_o,
    // mode, results, flags and targets
    input wire logic               active_run_select_i,
    input wire logic [7:0]         irq_pin_routing_i,
    input wire logic               result_valid_i,
    input wire logic [PRESS_W-1:0] pressure_result_i,
    input wire logic [15:0]        pressure_target_i,
    input wire logic [7:0]         src_flags_i,
    input wire logic [PRESS_W-1:0] alarm_press_target_o,
    input wire logic               target_captured_o,
    input wire logic               acq_start_o,
    // pads
    input wire logic               irq_pin_a_o,
    input wire logic               irq_pin_a_oe_o,
    input wire logic               irq_pin_b_o,
    input wire logic               irq_pin_b_oe_o
);
    logic [7:0]  ctl_q, cfg_q, en_q, rd_exp;
    logic        arm_q, seen_q, hit_a, hit_b;
    logic [1:0]  exp_a, exp_b;
    int unsigned gap_q;
    wire         wr_ctl = reg_wr_i && reg_addr_i == ADDR_ACQ_ALARM_CTRL;
    wire         wr_cfg = reg_wr_i && reg_addr_i == ADDR_IRQ_PIN_CFG;
    wire         wr_en  = reg_wr_i && reg_addr_i == ADDR_IRQ_SRC_EN;

    // expected read data and pad state, from shadow copies of the bank
    assign rd_exp =
        (reg_addr_i == ADDR_ACQ_ALARM_CTRL) ? ctl_q :
        (reg_addr_i == ADDR_IRQ_PIN_CFG) ? cfg_q :
        (reg_addr_i == ADDR_IRQ_SRC_EN) ? en_q : READ_UNMAPPED;
    assign hit_a = |(src_flags_i & en_q & irq_pin_routing_i);
    assign hit_b = |(src_flags_i & en_q & ~irq_pin_routing_i);
    // open drain lets go of the line when idle, so oe is the real test
    assign exp_a = (cfg_q[4] && !hit_a) ? {cfg_q[5], 1'b0}
                                        : {hit_a ~^ cfg_q[5], 1'b1};
    assign exp_b = (cfg_q[0] && !hit_b) ? {cfg_q[1], 1'b0}
                                        : {hit_b ~^ cfg_q[1], 1'b1};

    // shadows, capture arming and the gap between interval pulses
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            ctl_q  <= RST_ACQ_ALARM_CTRL;
            cfg_q  <= RST_IRQ_PIN_CFG;
            en_q   <= RST_IRQ_SRC_EN;
            arm_q  <= 1'b0;
            gap_q  <= 0;
            seen_q <= 1'b0;
        end else begin
            if (wr_ctl) ctl_q <= reg_wdata_i & MASK_ACQ_ALARM_CTRL;
            if (wr_cfg) cfg_q <= reg_wdata_i & MASK_IRQ_PIN_CFG;
            if (wr_en) en_q <= reg_wdata_i & MASK_IRQ_SRC_EN;
            if (wr_ctl) arm_q <= reg_wdata_i[5] & (arm_q | ~ctl_q[5]);
            else if (result_valid_i && ctl_q[5]) arm_q <= 1'b0;
            gap_q  <= (!active_run_select_i || acq_start_o) ? 1 : gap_q + 1;
            seen_q <= active_run_select_i && (seen_q || acq_start_o);
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_capt; result_valid_i && arm_q && ctl_q[5]; endsequence

    property p_read; reg_rd_i |=> reg_rdata_o == $past(rd_exp); endproperty
    property p_hold; !reg_rd_i |=> $stable(reg_rdata_o); endproperty
    property p_prog;
        !ctl_q[4] |=> alarm_press_target_o == {$past(pressure_target_i), 4'h0};
    endproperty
    property p_capt; s_capt |-> ##2 target_captured_o; endproperty
    property p_capt_val;
        s_capt ##1 ctl_q[4] |=> alarm_press_target_o == $past(pressure_result_i, 2);
    endproperty
    property p_pad_a; 1 |=> {irq_pin_a_o, irq_pin_a_oe_o} == $past(exp_a); endproperty
    property p_pad_b; 1 |=> {irq_pin_b_o, irq_pin_b_oe_o} == $past(exp_b); endproperty
    property p_period;
        acq_start_o && seen_q |-> gap_q == (CYCLES_PER_UNIT_P << ctl_q[3:0]);
    endproperty
    property p_idle; !active_run_select_i [*3] |-> !acq_start_o; endproperty

    a_read: assert property (p_read)
        else $error("read data differs from the bank");
    a_hold: assert property (p_hold)
        else $error("read data moved without a read");
    a_prog: assert property (p_prog)
        else $error("programmed target not used");
    a_capt: assert property (p_capt)
        else $error("capture flag late");
    a_capt_val: assert property (p_capt_val)
        else $error("captured target wrong");
    a_pad_a: assert property (p_pad_a)
        else $error("pad a state wrong");
    a_pad_b: assert property (p_pad_b)
        else $error("pad b state wrong");
    a_period: assert property (p_period)
        else $error("interval period wrong");
    a_idle: assert property (p_idle)
        else $error("interval pulse in standby");
endmodule : sensor_ctrl_checker

bind sensor_acq_irq_control_regs sensor_ctrl_checker
    #(.CYCLES_PER_UNIT_P(CYCLES_PER_UNIT_P)) u_chk (.*);

/* verification/test_sensor_acq_irq_control_regs.sv */
// self-checking bench for the sensor acquisition and interrupt bank
module test_sensor_acq_irq_control_regs import sensor_ctrl_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic               clk_i, rst_n_i, reg_wr_i, reg_rd_i;
    logic               active_run_select_i, result_valid_i;
    logic               target_captured_o, acq_start_o;
    logic               irq_pin_a_o, irq_pin_a_oe_o;
    logic               irq_pin_b_o, irq_pin_b_oe_o;
    logic [7:0]         reg_addr_i, reg_wdata_i, reg_rdata_o, rd, cfg;
    logic [7:0]         src_flags_i, irq_pin_routing_i, temperature_target_i;
    logic [15:0]        pressure_target_i;
    logic [PRESS_W-1:0] pressure_result_i, alarm_press_target_o;
    logic [TEMP_W-1:0]  temp_result_i, alarm_temp_target_o;
    logic [7:0]         msk [4];
    int                 failures, n_tests, n;

    sensor_acq_irq_control_regs #(.CYCLES_PER_UNIT_P(4)) uut (.*);
    host_model u_host (.*);

    // 20 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic close_out;
        $display("checks %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : close_out

    function automatic logic [1:0] pad(logic pol, logic od, logic hit);
        pad = (od && !hit) ? {pol, 1'b0} : {hit ~^ pol, 1'b1};
    endfunction : pad

    task automatic pads(logic ha, logic hb);
        repeat (2) @(negedge clk_i);
        check("pad a", {irq_pin_a_o, irq_pin_a_oe_o}, pad(cfg[5], cfg[4], ha));
        check("pad b", {irq_pin_b_o, irq_pin_b_oe_o}, pad(cfg[1], cfg[0], hb));
    endtask : pads

    task automatic cap(logic [19:0] pv, logic [11:0] tv,
                       logic [19:0] pe, logic [11:0] te);
        @(negedge clk_i);
        result_valid_i = 1'b1;
        pressure_result_i = pv;
        temp_result_i = tv;
        @(negedge clk_i);
        result_valid_i = 1'b0;
        repeat (2) @(negedge clk_i);
        check("press target", alarm_press_target_o, pe);
        check("temp target", alarm_temp_target_o, te);
    endtask : cap

    // counts edges between two interval pulses, bounded
    task automatic period(output int cnt);
        cnt = 0;
        while (acq_start_o !== 1'b1 && cnt < 200) begin
            @(negedge clk_i);
            cnt++;
        end
        cnt = 0;
        do begin
            @(negedge clk_i);
            cnt++;
        end while (acq_start_o !== 1'b1 && cnt < 200);
    endtask : period

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        rst_n_i = 1'b0;
        active_run_select_i = 1'b0;
        result_valid_i = 1'b0;
        src_flags_i = 8'h00;
        irq_pin_routing_i = 8'h00;
        pressure_result_i = '0;
        temp_result_i = '0;
        pressure_target_i = 16'h1234;
        temperature_target_i = 8'hab;
        msk = '{MASK_ACQ_ALARM_CTRL, MASK_IRQ_PIN_CFG, MASK_IRQ_SRC_EN,
                READ_UNMAPPED};
        repeat (6) @(negedge clk_i);
        rst_n_i = 1'b1;
        // reset values, writable bits and the unmapped slot
        for (int i = 0; i < 4; i++) begin
            u_host.rd(ADDR_ACQ_ALARM_CTRL + i[7:0], rd);
            check("reset", rd, 8'h00);
            u_host.wr(ADDR_ACQ_ALARM_CTRL + i[7:0], 8'hff);
            u_host.rd(ADDR_ACQ_ALARM_CTRL + i[7:0], rd);
            check("mask", rd, msk[i]);
        end
        // each source alone while all flags are up
        cfg = 8'h00;
        u_host.wr(ADDR_IRQ_PIN_CFG, cfg);
        src_flags_i = 8'hff;
        irq_pin_routing_i = 8'h55;
        u_host.wr(ADDR_IRQ_SRC_EN, 8'h00);
        pads(1'b0, 1'b0);
        for (int i = 0; i < 8; i++) begin
            u_host.wr(ADDR_IRQ_SRC_EN, 8'h01 << i);
            pads(i % 2 == 0, i % 2 == 1);
        end
        // every polarity and drive combination on both pads
        irq_pin_routing_i = 8'h01;
        u_host.wr(ADDR_IRQ_SRC_EN, 8'h03);
        for (int m = 0; m < 4; m++) begin
            cfg = {2'b00, m[1:0], 2'b00, m[1:0]};
            u_host.wr(ADDR_IRQ_PIN_CFG, cfg);
            for (int f = 0; f < 4; f++) begin
                src_flags_i = {6'h00, f[1:0]};
                pads(f[0], f[1]);
            end
        end
        irq_pin_routing_i = 8'h03;
        src_flags_i = 8'h03;
        pads(1'b1, 1'b0);
        // programmed targets, then capture and recapture
        u_host.wr(ADDR_ACQ_ALARM_CTRL, 8'h00);
        cap(20'h54321, 12'h9a5, 20'h12340, 12'hab0);
        check("captured", target_captured_o, 1'b0);
        u_host.wr(ADDR_ACQ_ALARM_CTRL, 8'h30);
        cap(20'h54321, 12'h9a5, 20'h54321, 12'h9a5);
        check("captured", target_captured_o, 1'b1);
        cap(20'h11111, 12'h111, 20'h54321, 12'h9a5);
        u_host.wr(ADDR_ACQ_ALARM_CTRL, 8'h10);
        u_host.wr(ADDR_ACQ_ALARM_CTRL, 8'h30);
        cap(20'habcde, 12'h0f0, 20'habcde, 12'h0f0);
        // interval length for small exponents, then standby
        for (int e = 0; e < 3; e++) begin
            active_run_select_i = 1'b0;
            u_host.wr(ADDR_ACQ_ALARM_CTRL, e[7:0]);
            active_run_select_i = 1'b1;
            period(n);
            check("period", n, 4 << e);
        end
        active_run_select_i = 1'b0;
        n = 0;
        repeat (40) begin
            @(negedge clk_i);
            if (acq_start_o !== 1'b0)
                n++;
        end
        check("standby pulses", n, 0);
        close_out();
    end

    // watchdog well beyond the expected run length
    initial begin
        #2_000_000;
        failures++;
        close_out();
    end
endmodule : test_sensor_acq_irq_control_regs
